/* dv/cbst_mem_model.sv */
// partner model: address translation and data cache behind the engine
// assumes each request is held until its one-cycle ack or done pulse
module cbst_mem_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench controls: answer delay and lookup outcome
   input wire logic [3:0] lat,
   input wire logic [6:0] cfg,
   // requests from the engine
   input wire logic xl_req,
   input wire logic [31:0] xl_addr,
   input wire logic dc_req,
   input wire logic [31:0] dc_addr,
   input wire logic dc_copy_req,
   input wire logic dc_fill_req,
   // answers
   output logic xl_ack,
   output logic xl_fault,
   output logic xl_load_ok,
   output logic xl_direct_store,
   output logic xl_inhibit,
   output logic xl_guarded,
   output logic [31:0] xl_paddr,
   output logic dc_ack,
   output logic dc_hit,
   output logic dc_modified,
   output logic dc_copy_done,
   output logic dc_fill_done
);
   logic [3:0] rq; // fill, copy, lookup, translate
   logic [3:0] ak; // matching one-cycle answers
   logic [3:0] wt [4]; // cycles waited per channel
   int copies = 0; // finished copies, read by the bench
   int fills = 0; // finished fills
   logic [31:0] last_addr = '0; // block of the last copy or fill
   assign rq = {dc_fill_req, dc_copy_req, dc_req, xl_req};
   assign {dc_fill_done, dc_copy_done, dc_ack, xl_ack} = ak;
   // flat map; outside the ack the result bits lie, as a real unit's may
   assign xl_paddr = xl_ack ? xl_addr : ~xl_addr;
   assign {xl_fault, xl_load_ok, xl_direct_store, xl_inhibit, xl_guarded}
      = xl_ack ? cfg[6:2] : ~cfg[6:2];
   assign {dc_hit, dc_modified} = dc_ack ? cfg[1:0] : ~cfg[1:0];
   // each channel answers lat + 1 cycles after its request shows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ak <= '0;
         wt <= '{default: '0};
      end else begin
         for (int i = 0; i < 4; i++) begin
            ak[i] <= 1'b0;
            if (rq[i] && !ak[i] && wt[i] == lat) begin
               ak[i] <= 1'b1;
               wt[i] <= '0;
            end else if (rq[i] && !ak[i]) begin
               wt[i] <= wt[i] + 4'h1;
            end
         end
      end
   end
   // traffic record; the address is taken while the request stands
   always @(posedge pclk) begin
      if (dc_copy_done) copies <= copies + 1;
      if (dc_fill_done) fills <= fills + 1;
      if (dc_copy_req || dc_fill_req) last_addr <= dc_addr;
   end
endmodule

/* dv/cbst_unit_monitor.sv */
// checker for the store-back and touch engine, bound to cbst_unit
// assumes one clock domain and an asynchronous active-low reset
module cbst_unit_monitor #(
   parameter int BLOCK = 32 // cache block bytes
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // issue side
   input wire logic op_valid,
   input wire logic op_is_touch,
   input wire logic [31:0] op_instr,
   input wire logic [31:0] base_val,
   input wire logic [31:0] index_val,
   input wire logic op_ready,
   input wire logic done_valid,
   input wire logic exc_valid,
   // translation and cache
   input wire logic xl_req,
   input wire logic [31:0] xl_addr,
   input wire logic xl_ack,
   input wire logic dc_ack,
   input wire logic dc_hit,
   input wire logic dc_modified,
   input wire logic dc_copy_req,
   input wire logic dc_fill_req
);
   logic touch_q; // op in flight is a touch
   logic first_q; // first translation not yet answered
   logic dirty_q; // lookup found a modified block
   logic [31:0] ea_q; // effective address of the op
   wire logic take = op_valid && op_ready;
   wire logic [31:0] mask = ~(32'(BLOCK) - 32'h1);
   // capture each op at take; a zero base selector reads as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         touch_q <= 1'b0;
         first_q <= 1'b0;
         dirty_q <= 1'b0;
         ea_q <= '0;
      end else if (take) begin
         touch_q <= op_is_touch;
         first_q <= 1'b1;
         dirty_q <= 1'b0;
         ea_q <= (op_instr[20:16] == 5'h00) ? index_val
                 : base_val + index_val;
      end else begin
         if (xl_ack) first_q <= 1'b0;
         if (dc_ack && dc_hit && dc_modified) dirty_q <= 1'b1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   take_busy_a: assert property (take |=> !op_ready)
      else $error("op_ready high after a take");
   done_pulse_a: assert property (done_valid |-> op_ready ##1 !done_valid)
      else $error("done not a single pulse with op_ready");
   done_bound_a: assert property (take |-> ##[3:400] done_valid)
      else $error("operation did not complete");
   xl_hold_a: assert property (xl_req && !xl_ack |=> xl_req)
      else $error("translation request dropped early");
   exc_touch_a: assert property (exc_valid |-> !touch_q)
      else $error("touch raised a trap");
   exc_done_a: assert property (exc_valid |-> ##1 done_valid)
      else $error("trap not followed by done");
   first_ea_a: assert property ($rose(xl_req) && first_q |->
      xl_addr == (ea_q & mask)) else $error("wrong effective address");
   copy_dirty_a: assert property (dc_copy_req |-> !touch_q && dirty_q)
      else $error("copy without a modified store-back hit");
   fill_touch_a: assert property (dc_fill_req |-> touch_q)
      else $error("store-back allocated a line");
   cover property (dc_copy_req);
   cover property (dc_fill_req ##1 !dc_fill_req [*2] ##1 dc_fill_req);
   cover property (exc_valid);
endmodule

bind cbst_unit cbst_unit_monitor #(.BLOCK(BLOCK)) u_mon (
   .pclk, .presetn, .op_valid, .op_is_touch, .op_instr, .base_val,
   .index_val, .op_ready, .done_valid, .exc_valid, .xl_req, .xl_addr,
   .xl_ack, .dc_ack, .dc_hit, .dc_modified, .dc_copy_req, .dc_fill_req
);

/* dv/cbst_unit_tb.sv */
// self-checking bench for the store-back and touch engine
// assumes the partner model answers translation and cache requests
module cbst_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // drivers, all idle at time zero
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, op_valid = 1'b0, op_is_touch = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, op_instr = '0, base_val = '0, index_val = '0;
   logic [3:0] lat = '0; // partner answer delay
   logic [6:0] cfg = '0; // fault, load ok, direct, inhibit, guard, hit, dirty
   // design outputs
   logic [31:0] prdata, exc_addr, xl_addr, xl_paddr, dc_addr, rd;
   logic pready, pslverr, op_ready, done_valid, exc_valid, xl_req, xl_ack;
   logic xl_fault, xl_load_ok, xl_direct_store, xl_inhibit, xl_guarded;
   logic dc_req, dc_ack, dc_hit, dc_modified, dc_copy_req, dc_copy_done;
   logic dc_fill_req, dc_fill_done, ex, er;
   int mismatches = 0, tests_run = 0, c0, f0, ncopy, nfill;

   cbst_unit #(.BLOCK(32)) u_dut (
      .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_is_touch,
      .op_instr, .base_val, .index_val, .op_ready, .done_valid, .exc_valid,
      .exc_addr, .xl_req, .xl_addr, .xl_ack, .xl_fault, .xl_load_ok,
      .xl_direct_store, .xl_inhibit, .xl_guarded, .xl_paddr, .dc_req,
      .dc_addr, .dc_ack, .dc_hit, .dc_modified, .dc_copy_req, .dc_copy_done,
      .dc_fill_req, .dc_fill_done
   );
   cbst_mem_model u_mem (
      .pclk, .presetn, .lat, .cfg, .xl_req, .xl_addr, .dc_req, .dc_addr,
      .dc_copy_req, .dc_fill_req, .xl_ack, .xl_fault, .xl_load_ok,
      .xl_direct_store, .xl_inhibit, .xl_guarded, .xl_paddr, .dc_ack,
      .dc_hit, .dc_modified, .dc_copy_done, .dc_fill_done
   );

   // 50 MHz clock
   initial begin
      forever #10 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
         input string m);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, seen,
                  exp);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // issue one op, wait for completion and note any trap
   task automatic run_op(input logic t, input logic [1:0] h,
         input logic [4:0] s, input logic [31:0] b, input logic [31:0] x);
      bit seen;
      seen = 1'b0;
      ex = 1'b0;
      c0 = u_mem.copies;
      f0 = u_mem.fills;
      @(posedge pclk);
      op_valid <= 1'b1;
      op_is_touch <= t;
      op_instr <= {9'h000, h, s, 16'h0000};
      base_val <= b;
      index_val <= x;
      @(posedge pclk);
      op_valid <= 1'b0;
      for (int n = 0; n < 400 && !seen; n++) begin
         @(negedge pclk);
         ex = ex | exc_valid;
         seen = done_valid === 1'b1;
      end
      ncopy = u_mem.copies - c0;
      nfill = u_mem.fills - f0;
      check(seen, 1'b1, "no completion");
   endtask

   // idle outputs, control reset value, unmapped address refused
   task automatic t_reset;
      check(op_ready, 1'b1, "ready after reset");
      check(done_valid | exc_valid | xl_req | dc_req, 1'b0, "idle");
      apb(1'b0, cbst_pkg::CTRL_OFS, '0);
      check(rd, cbst_pkg::CTRL_RESET, "control reset");
      apb(1'b0, 12'h100, '0);
      check(er, 1'b1, "unmapped error");
      check(rd, '0, "unmapped data");
      cfg <= 7'h20;
      apb(1'b1, cbst_pkg::CTRL_OFS, 32'h0000_0300);
      run_op(1'b1, 2'h1, 5'h00, '0, '0);
      check(nfill, 0, "touch off");
      apb(1'b1, cbst_pkg::CTRL_OFS, cbst_pkg::CTRL_RESET);
   endtask

   // store-back: dirty hit, clean hit, miss, fault, refused load
   task automatic t_store;
      logic [6:0] k [5] = '{7'h23, 7'h22, 7'h20, 7'h63, 7'h03};
      logic [31:0] ea;
      for (int i = 0; i < 5; i++) begin
         ea = i[0] ? 32'h1000_0065 : 32'h0000_0025; // zero selector: index
         cfg <= k[i];
         run_op(1'b0, 2'h0, i[0] ? 5'h03 : 5'h00, 32'h1000_0040,
                32'h0000_0025);
         check(ncopy, (i == 0) ? 1 : 0, "copies");
         check(nfill, 0, "store allocated");
         check(ex, i > 2, "trap flag");
         if (i == 0) check(u_mem.last_addr, 32'h20, "copy block");
         if (i > 2) check(exc_addr, ea, "trap address");
      end
      apb(1'b0, cbst_pkg::WB_CNT_OFS, '0);
      check(rd, 32'h1, "copy counter");
   endtask

   // touch hints under growing partner delay, then silent drops
   task automatic t_touch;
      logic [6:0] k [5] = '{7'h60, 7'h00, 7'h30, 7'h28, 7'h24};
      logic [31:0] last [4] = '{32'h2100, 32'h2140, 32'h2100, 32'h20c0};
      for (int h = 0; h < 4; h++) begin
         cfg <= 7'h20;
         lat <= h[3:0];
         // hint 00 is what a two-operand touch carries
         run_op(1'b1, h[1:0], 5'h01, 32'h0000_2000, 32'h0000_0110);
         check(nfill, h[0] ? 3 : 1, "fills");
         check(u_mem.last_addr, last[h], "last block");
         check(ex, 1'b0, "touch trap");
      end
      lat <= 4'h0;
      for (int i = 0; i < 5; i++) begin
         cfg <= k[i];
         run_op(1'b1, 2'h1, 5'h00, 32'h0, 32'h0000_3004);
         check(nfill, 0, "dropped fills");
         check(ex, 1'b0, "dropped trap");
      end
      apb(1'b0, cbst_pkg::DROP_CNT_OFS, '0);
      check(rd, 32'h5, "drop counter");
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // watchdog, well past the few hundred cycles the tests take
   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      conclude();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      t_reset();
      t_store();
      t_touch();
      conclude();
   end
endmodule

/* rtl/cbst_decode.sv */
// operand capture stage: decodes the instruction word and forms the
// effective address when the engine takes an operation
// assumes register values are valid in the same cycle as take
module cbst_decode (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // capture request
   input wire logic take,
   input wire logic is_touch,
   input wire logic [31:0] instr,
   input wire logic [31:0] base_val,
   input wire logic [31:0] index_val,
   // captured operation
   output logic [31:0] ea_q,
   output logic [1:0] hint_q,
   output logic touch_q
);

   logic [cbst_pkg::SEL_W-1:0] base_sel; // base_reg_select field

   assign base_sel = instr[cbst_pkg::BASE_SEL_LSB +: cbst_pkg::SEL_W];

   // capture on take; store-back forces a plain hint
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ea_q <= 32'h0000_0000;
         hint_q <= 2'h0;
         touch_q <= 1'b0;
      end else if (clk_en && take) begin
         ea_q <= cbst_pkg::eff_addr(base_sel, base_val, index_val); // [R01] [R07]
         hint_q <= is_touch ? instr[cbst_pkg::HINT_LSB +: 2]
                            : cbst_pkg::HINT_BYTE; // [R14]
         touch_q <= is_touch;
      end
   end

endmodule

/* rtl/cbst_pkg.sv */
// shared constants for the cache block store-back and touch unit
// assumes a 32-bit effective address and an APB register port
package cbst_pkg;

   // apb register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000; // control
   localparam logic [11:0] STATUS_OFS = 12'h004; // engine state
   localparam logic [11:0] WB_CNT_OFS = 12'h008; // blocks copied out
   localparam logic [11:0] FILL_CNT_OFS = 12'h00c; // blocks fetched
   localparam logic [11:0] DROP_CNT_OFS = 12'h010; // touches dropped

   // control register fields and reset value
   localparam int CTRL_TOUCH_EN_BIT = 0; // touches allowed
   localparam int CTRL_STREAM_LSB = 8; // blocks per streamed touch
   localparam int STREAM_W = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0301;

   // instruction word fields, bit 0 is the lsb
   localparam int HINT_LSB = 21; // touch_hint, two bits
   localparam int BASE_SEL_LSB = 16; // base_reg_select, five bits
   localparam int SEL_W = 5;

   // touch_hint encodings
   localparam logic [1:0] HINT_BYTE = 2'h0;
   localparam logic [1:0] HINT_UP = 2'h1;
   localparam logic [1:0] HINT_RSVD = 2'h2;
   localparam logic [1:0] HINT_DOWN = 2'h3;

   // default cache block size in bytes
   localparam int BLOCK_BYTES = 32;
   localparam int CNT_W = 16;

   // engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_XLATE = 3'b010,
      ST_LOOKUP = 3'b011,
      ST_COPY = 3'b100,
      ST_FILL = 3'b101,
      ST_NEXT = 3'b110,
      ST_DONE = 3'b111
   } state_t;

   // base plus index, a zero base selector reads as zero
   function automatic logic [31:0] eff_addr(input logic [SEL_W-1:0] sel,
                                            input logic [31:0] base,
                                            input logic [31:0] index);
      eff_addr = (sel == '0) ? index : base + index;
   endfunction

   // clear the offset bits inside a block
   function automatic logic [31:0] block_align(input logic [31:0] a,
                                               input int bytes);
      block_align = a & ~(32'(bytes) - 32'h0000_0001);
   endfunction

endpackage

/* rtl/cbst_regs.sv */
// apb slave for the control word and the engine's counters
// assumes a standard apb master; answers with one wait-free access
module cbst_regs (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // block state
   input wire logic [31:0] status,
   input wire logic [cbst_pkg::CNT_W-1:0] wb_cnt,
   input wire logic [cbst_pkg::CNT_W-1:0] fill_cnt,
   input wire logic [cbst_pkg::CNT_W-1:0] drop_cnt,
   output logic [31:0] ctrl_q
);

   logic setup; // first cycle of a transfer
   logic hit; // address is mapped
   logic [31:0] rd; // read mux

   assign setup = psel && !penable;

   // read mux and address decode
   always_comb begin
      hit = 1'b1;
      rd = 32'h0000_0000;
      unique case (paddr)
         cbst_pkg::CTRL_OFS: rd = ctrl_q;
         cbst_pkg::STATUS_OFS: rd = status;
         cbst_pkg::WB_CNT_OFS: rd = 32'(wb_cnt);
         cbst_pkg::FILL_CNT_OFS: rd = 32'(fill_cnt);
         cbst_pkg::DROP_CNT_OFS: rd = 32'(drop_cnt);
         default: hit = 1'b0; // unmapped answers with an error
      endcase
   end

   // answer is prepared in the setup cycle, so access takes one edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         pready <= setup;
         pslverr <= setup && !hit;
         prdata <= (setup && !pwrite) ? rd : 32'h0000_0000;
      end
   end

   // only the control word is writable; counters are read only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= cbst_pkg::CTRL_RESET;
      end else if (clk_en && psel && penable && pready && pwrite &&
                   paddr == cbst_pkg::CTRL_OFS) begin
         ctrl_q <= pwdata;
      end
   end

endmodule

/* rtl/cbst_unit.sv */
// cache block store-back and touch engine: takes one operation at a
// time from issue, translates it, looks the block up in the data
// cache and asks the cache to copy out or fetch blocks
// assumes translation and cache answer with a one-cycle ack or done
// and keep their result bits valid in that cycle

// Operation
// R01: store-back address is base plus index, zero base
// R02: modified hit copies whole block to memory
// R03: store-back translated and checked like a load
// R04: store-back never writes fixed-point exception state
// R05: touch fetches the addressed block ahead of use
// R06: touch never raises any exception
// R07: touch address is base plus index, zero base
// R08: touch in direct-store segment is a no-op
// R09: touch forbidden by load protection does nothing
// R10: hint ignored for inhibited or guarded locations
// R11: hint selects byte, ascending or descending blocks
// R12: two-operand touch encodes a zero hint
// R13: touch leaves condition and exception state alone
// R14: reserved hint acts as plain touch, no error
// R15: clean or absent block: no write, no allocation
module cbst_unit #(
   parameter int BLOCK = cbst_pkg::BLOCK_BYTES // cache block bytes
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // issue side
   input wire logic op_valid,
   input wire logic op_is_touch,
   input wire logic [31:0] op_instr,
   input wire logic [31:0] base_val,
   input wire logic [31:0] index_val,
   output logic op_ready,
   output logic done_valid,
   output logic exc_valid,
   output logic [31:0] exc_addr,
   // address translation
   output logic xl_req,
   output logic [31:0] xl_addr,
   input wire logic xl_ack,
   input wire logic xl_fault,
   input wire logic xl_load_ok,
   input wire logic xl_direct_store,
   input wire logic xl_inhibit,
   input wire logic xl_guarded,
   input wire logic [31:0] xl_paddr,
   // data cache
   output logic dc_req,
   output logic [31:0] dc_addr,
   input wire logic dc_ack,
   input wire logic dc_hit,
   input wire logic dc_modified,
   output logic dc_copy_req,
   input wire logic dc_copy_done,
   output logic dc_fill_req,
   input wire logic dc_fill_done
);

   cbst_pkg::state_t state_q; // engine state
   logic [31:0] ea; // captured effective address
   logic [1:0] hint; // captured touch_hint
   logic touch; // captured operation is a touch
   logic [31:0] ctrl; // control word
   logic [31:0] cur_q; // block currently worked on
   logic [cbst_pkg::STREAM_W-1:0] left_q; // blocks still to touch
   logic [cbst_pkg::STREAM_W-1:0] total; // blocks per stream
   logic [cbst_pkg::CNT_W-1:0] wb_cnt_q; // copies done
   logic [cbst_pkg::CNT_W-1:0] fill_cnt_q; // fetches done
   logic [cbst_pkg::CNT_W-1:0] drop_cnt_q; // touches discarded
   logic take; // operation accepted this cycle
   logic xl_stop; // translation ends the operation
   logic xl_drop; // touch dropped at translation
   logic [31:0] status; // status word for software

   assign take = op_valid && op_ready;
   assign total = ctrl[cbst_pkg::CTRL_STREAM_LSB +: cbst_pkg::STREAM_W];
   assign status = {28'h000_0000, (state_q != cbst_pkg::ST_IDLE),
                    3'(state_q)};

   // a fault or a forbidden load stops either operation
   assign xl_stop = xl_fault || !xl_load_ok;
   // a touch also stops where the hint has no meaning
   assign xl_drop = xl_stop || xl_direct_store || // [R08] [R09]
                    xl_inhibit || xl_guarded; // [R10]

   // operand capture
   cbst_decode u_decode (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .take(take),
      .is_touch(op_is_touch),
      .instr(op_instr),
      .base_val(base_val),
      .index_val(index_val),
      .ea_q(ea),
      .hint_q(hint),
      .touch_q(touch)
   );

   // register port
   cbst_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .status(status),
      .wb_cnt(wb_cnt_q),
      .fill_cnt(fill_cnt_q),
      .drop_cnt(drop_cnt_q),
      .ctrl_q(ctrl)
   );

   // engine sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= cbst_pkg::ST_IDLE;
      end else if (clk_en) begin
         unique case (state_q)
            cbst_pkg::ST_IDLE: begin
               if (take) begin
                  state_q <= cbst_pkg::ST_START;
               end
            end
            cbst_pkg::ST_START: begin
               // touches switched off by software complete at once
               if (touch && !ctrl[cbst_pkg::CTRL_TOUCH_EN_BIT]) begin
                  state_q <= cbst_pkg::ST_DONE;
               end else begin
                  state_q <= cbst_pkg::ST_XLATE;
               end
            end
            cbst_pkg::ST_XLATE: begin
               if (xl_req && xl_ack) begin
                  if (touch ? xl_drop : xl_stop) begin
                     state_q <= cbst_pkg::ST_DONE; // [R03] [R09]
                  end else begin
                     state_q <= cbst_pkg::ST_LOOKUP;
                  end
               end
            end
            cbst_pkg::ST_LOOKUP: begin
               if (dc_req && dc_ack) begin
                  if (touch) begin
                     // miss fetches, hit moves on
                     state_q <= dc_hit ? cbst_pkg::ST_NEXT
                                       : cbst_pkg::ST_FILL; // [R05]
                  end else if (dc_hit && dc_modified) begin
                     state_q <= cbst_pkg::ST_COPY; // [R02]
                  end else begin
                     state_q <= cbst_pkg::ST_DONE; // [R15]
                  end
               end
            end
            cbst_pkg::ST_COPY: begin
               if (dc_copy_done) begin
                  state_q <= cbst_pkg::ST_DONE;
               end
            end
            cbst_pkg::ST_FILL: begin
               if (dc_fill_done) begin
                  state_q <= cbst_pkg::ST_NEXT;
               end
            end
            cbst_pkg::ST_NEXT: begin
               state_q <= (left_q == '0) ? cbst_pkg::ST_DONE
                                         : cbst_pkg::ST_XLATE; // [R11]
            end
            cbst_pkg::ST_DONE: begin
               state_q <= cbst_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // block address and stream length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_q <= 32'h0000_0000;
         left_q <= '0;
      end else if (clk_en) begin
         if (state_q == cbst_pkg::ST_START) begin
            cur_q <= cbst_pkg::block_align(ea, BLOCK);
            // byte and reserved hints cover one block only
            if ((hint == cbst_pkg::HINT_UP || hint == cbst_pkg::HINT_DOWN)
                && total != '0) begin
               left_q <= total - 1'b1; // [R11]
            end else begin
               left_q <= '0; // [R14]
            end
         end else if (state_q == cbst_pkg::ST_NEXT && left_q != '0) begin
            // step one block; a stream wraps past the ends modulo the address space
            cur_q <= (hint == cbst_pkg::HINT_DOWN) ? cur_q - 32'(BLOCK)
                                                   : cur_q + 32'(BLOCK);
            left_q <= left_q - 1'b1; // [R11]
         end
      end
   end

   // a stream wraps modulo the address space; each step retranslates,
   // so a wrapped block still passes the protection checks

   // translation request, held until acknowledged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xl_req <= 1'b0;
         xl_addr <= 32'h0000_0000;
      end else if (clk_en) begin
         if (xl_req && xl_ack) begin
            xl_req <= 1'b0;
         end else if (state_q == cbst_pkg::ST_XLATE && !xl_req) begin
            xl_req <= 1'b1; // [R03]
            xl_addr <= cur_q;
         end
      end
   end

   // cache lookup, copy-out and fetch requests
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dc_req <= 1'b0;
         dc_addr <= 32'h0000_0000;
         dc_copy_req <= 1'b0;
         dc_fill_req <= 1'b0;
      end else if (clk_en) begin
         if (state_q == cbst_pkg::ST_XLATE && xl_req && xl_ack &&
             !(touch ? xl_drop : xl_stop)) begin
            dc_req <= 1'b1;
            dc_addr <= cbst_pkg::block_align(xl_paddr, BLOCK);
         end else if (dc_req && dc_ack) begin
            dc_req <= 1'b0;
            // whole block goes out only when present and modified
            dc_copy_req <= !touch && dc_hit && dc_modified; // [R02] [R15]
            dc_fill_req <= touch && !dc_hit; // [R05]
         end else begin
            if (dc_copy_done) begin
               dc_copy_req <= 1'b0;
            end
            if (dc_fill_done) begin
               dc_fill_req <= 1'b0;
            end
         end
      end
   end

   // issue handshake and completion; only a store-back may trap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_ready <= 1'b1;
         done_valid <= 1'b0;
         exc_valid <= 1'b0;
         exc_addr <= 32'h0000_0000;
      end else if (clk_en) begin
         done_valid <= 1'b0;
         exc_valid <= 1'b0;
         if (take) begin
            op_ready <= 1'b0;
         end
         if (state_q == cbst_pkg::ST_XLATE && xl_req && xl_ack &&
             !touch && xl_stop) begin
            exc_valid <= 1'b1; // [R03] [R06]
            exc_addr <= ea;
         end
         // completion carries no condition or exception update
         if (state_q == cbst_pkg::ST_DONE) begin
            done_valid <= 1'b1; // [R04] [R13]
            op_ready <= 1'b1;
         end
      end
   end

   // software-visible counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wb_cnt_q <= '0;
         fill_cnt_q <= '0;
         drop_cnt_q <= '0;
      end else if (clk_en) begin
         if (dc_copy_req && dc_copy_done) begin
            wb_cnt_q <= wb_cnt_q + 1'b1;
         end
         if (dc_fill_req && dc_fill_done) begin
            fill_cnt_q <= fill_cnt_q + 1'b1;
         end
         if (state_q == cbst_pkg::ST_XLATE && xl_req && xl_ack &&
             touch && xl_drop) begin
            drop_cnt_q <= drop_cnt_q + 1'b1; // [R06]
         end
      end
   end

endmodule
